// [logic/sbs_pkg.sv]
`default_nettype none
package sbs_pkg;
  // geometry of one burst and of one byte lane
  localparam int SBS_BURST_LEN = 4;
  localparam int SBS_LOW_BITS = 2;
  localparam int SBS_LANE_BITS = 8;
  localparam int SBS_LANE_WITH_PAR = SBS_LANE_BITS + 1;
  // default organisation: x36, four lanes, four parity bits
  localparam int SBS_LANES_DEFAULT = 4;
  localparam int SBS_ADDR_W_DEFAULT = 10;
  // sleep request latency, in clock cycles
  localparam int SBS_SLEEP_ENTER_CYC = 2;
  localparam int SBS_SLEEP_EXIT_CYC = 2;
  // burst order select level for interleaved order
  localparam logic SBS_ORDER_INTERLEAVED = 1'b1;
  // reset values
  localparam logic [SBS_LOW_BITS-1:0] SBS_CNT_RST = 2'h0;
  localparam logic SBS_VALID_RST = 1'b0;

  // active-low synchronous control strobes sampled together
  typedef struct packed {
    logic chip_select_n;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_step_n;
    logic global_write_n;
    logic byte_write_gate_n;
  } sbs_ctrl_type;

  // gray-coded along idle -> burst -> sleep
  typedef enum logic [1:0] {
    SBS_IDLE = 2'b00,
    SBS_BURST = 2'b01,
    SBS_SLEEP = 2'b11
  } sbs_state_type;
endpackage : sbs_pkg
`default_nettype wire

// [logic/sbs_interface.sv]
// Summary of operation
// - processor strobe start always begins a read
// - controller strobe start reads or writes
// - deselect with controller strobe, data high-impedance
// - both strobes high, step low: advance
// - both strobes high, step high: hold address
// - read data driven only while enable low
// - write when global or gated lane low
// - global write forces all lanes written
// - each lane enable writes its byte+parity
// - parity bit count follows lane count
// - inputs sampled on edge; enable is asynchronous
// - data pins high-impedance from power-up
// - high order select gives interleaved burst
// - low order select gives linear burst
// - sleep ignores inputs within two cycles
`default_nettype none
module sbs_interface
  import sbs_pkg::*;
#(
  parameter int LANES = SBS_LANES_DEFAULT,
  parameter int ADDR_W = SBS_ADDR_W_DEFAULT
) (
  input wire logic clk_i, // 50 MHz clock
  input wire logic rst_i, // async reset, active high
  input wire sbs_ctrl_type ctrl_i, // sampled strobes and write gates
  input wire logic [ADDR_W-1:0] addr_i, // word address, low bits are burst_addr_low
  input wire logic [LANES-1:0] byte_lane_write_n_i, // per-lane write enables
  input wire logic output_enable_n_i, // asynchronous output enable
  input wire logic burst_order_i, // 1 interleaved, 0 linear
  input wire logic sleep_request_i, // snooze request, active high
  input wire logic [LANES*SBS_LANE_BITS-1:0] data_i, // data pins, input side
  output logic [LANES*SBS_LANE_BITS-1:0] data_o, // data pins, output side
  output logic data_oe_o, // data pins driven while high
  input wire logic [LANES-1:0] parity_io_i, // parity pins, input side
  output logic [LANES-1:0] parity_io_o, // parity pins, output side
  output logic parity_io_oe_o, // parity pins driven while high
  output logic asleep_o // inputs currently ignored
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam int HI_W = ADDR_W - SBS_LOW_BITS;

  // burst address from the external low pair and the step count
  function automatic logic [SBS_LOW_BITS-1:0] burst_addr(
    input logic [SBS_LOW_BITS-1:0] base,
    input logic [SBS_LOW_BITS-1:0] cnt,
    input logic order
  );
    if (order == SBS_ORDER_INTERLEAVED)
    begin
      burst_addr = base ^ cnt;
    end
    else
    begin
      burst_addr = base + cnt;
    end
  endfunction : burst_addr

  // which lanes a cycle writes; all zero means a read
  function automatic logic [LANES-1:0] lane_mask(
    input logic gw_n,
    input logic gate_n,
    input logic [LANES-1:0] lanes_n
  );
    if (!gw_n)
    begin
      lane_mask = '1;
    end
    else if (!gate_n)
    begin
      lane_mask = ~lanes_n;
    end
    else
    begin
      lane_mask = '0;
    end
  endfunction : lane_mask

  // one 9-bit cell per lane: byte plus its parity bit, lanes sized by LANES
  logic [LANES-1:0][SBS_LANE_WITH_PAR-1:0] mem [DEPTH];

  sbs_state_type state;
  logic [HI_W-1:0] addr_hi;
  logic [SBS_LOW_BITS-1:0] addr_base;
  logic [SBS_LOW_BITS-1:0] burst_cnt;
  logic [SBS_SLEEP_EXIT_CYC-1:0] sleep_pipe;
  logic sleep_now;
  logic start_proc;
  logic start_ctrl;
  logic deselect;
  logic continue_burst;
  logic [SBS_LOW_BITS-1:0] next_cnt;
  logic [ADDR_W-1:0] access_addr;
  logic [LANES-1:0] wr_lanes;
  logic access_rd;
  logic access_wr;
  logic rd_stage_valid;
  logic [LANES-1:0][SBS_LANE_WITH_PAR-1:0] rd_stage;
  logic out_valid;

  // sleep window: request seen at edge k is ignored-from by edge k+1,
  // and sampling resumes two edges after the request drops
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sleep_pipe <= '0;
    end
    else
    begin
      sleep_pipe <= {sleep_pipe[SBS_SLEEP_EXIT_CYC-2:0], sleep_request_i};
    end
  end

  assign sleep_now = |sleep_pipe;

  // cycle decode; every control is taken at the rising edge
  always_comb
  begin
    start_proc = !sleep_now && !ctrl_i.chip_select_n
                 && !ctrl_i.processor_addr_strobe_n;
    start_ctrl = !sleep_now && !ctrl_i.chip_select_n
                 && ctrl_i.processor_addr_strobe_n
                 && !ctrl_i.controller_addr_strobe_n;
    // processor strobe means nothing while chip select is off
    deselect = !sleep_now && ctrl_i.chip_select_n
               && !ctrl_i.controller_addr_strobe_n;
    continue_burst = !sleep_now && (state == SBS_BURST)
                     && ctrl_i.controller_addr_strobe_n
                     && (ctrl_i.processor_addr_strobe_n
                         || ctrl_i.chip_select_n);
    next_cnt = ctrl_i.burst_step_n ? burst_cnt
                                   : burst_cnt + 2'h1;
    wr_lanes = lane_mask(ctrl_i.global_write_n, ctrl_i.byte_write_gate_n,
                         byte_lane_write_n_i);
    if (start_proc || start_ctrl)
    begin
      access_addr = addr_i;
    end
    else
    begin
      access_addr = {addr_hi, burst_addr(addr_base, next_cnt, burst_order_i)};
    end
    // a processor start is a read whatever the write gates say
    access_wr = (start_ctrl || continue_burst) && (wr_lanes != '0);
    access_rd = start_proc || ((start_ctrl || continue_burst)
                               && (wr_lanes == '0));
  end

  // burst state, latched address and step counter
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= SBS_IDLE;
      addr_hi <= '0;
      addr_base <= SBS_CNT_RST;
      burst_cnt <= SBS_CNT_RST;
    end
    else if (sleep_now)
    begin
      state <= SBS_SLEEP;
    end
    else if (start_proc || start_ctrl)
    begin
      state <= SBS_BURST;
      addr_hi <= addr_i[ADDR_W-1:SBS_LOW_BITS];
      addr_base <= addr_i[SBS_LOW_BITS-1:0];
      burst_cnt <= SBS_CNT_RST;
    end
    else if (deselect || state == SBS_SLEEP)
    begin
      state <= SBS_IDLE;
      burst_cnt <= SBS_CNT_RST;
    end
    else if (continue_burst)
    begin
      burst_cnt <= next_cnt;
    end
  end

  // storage writes; per lane so unselected bytes keep their value
  always_ff @(posedge clk_i)
  begin
    if (access_wr)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (wr_lanes[i])
        begin
          mem[access_addr][i] <= {parity_io_i[i],
                                  data_i[i*SBS_LANE_BITS +: SBS_LANE_BITS]};
        end
      end
    end
  end

  // first read stage: array read at the access edge
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_stage_valid <= SBS_VALID_RST;
      rd_stage <= '0;
    end
    else
    begin
      rd_stage_valid <= access_rd;
      if (access_rd)
      begin
        rd_stage <= mem[access_addr];
      end
    end
  end

  // second stage drives the pins; pipelined, data one edge later
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_valid <= SBS_VALID_RST;
      data_o <= '0;
      parity_io_o <= '0;
    end
    else
    begin
      out_valid <= rd_stage_valid && !sleep_now;
      for (int i = 0; i < LANES; i++)
      begin
        data_o[i*SBS_LANE_BITS +: SBS_LANE_BITS] <= rd_stage[i][SBS_LANE_BITS-1:0];
        parity_io_o[i] <= rd_stage[i][SBS_LANE_BITS];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      asleep_o <= 1'b0;
    end
    else
    begin
      asleep_o <= sleep_request_i || sleep_pipe[0];
    end
  end

  // output enable must act without the clock, so the enables are the
  // only outputs that pass through a gate after the flip-flop
  assign data_oe_o = out_valid && !output_enable_n_i;
  assign parity_io_oe_o = out_valid && !output_enable_n_i;

endmodule : sbs_interface
`default_nettype wire

// [testbench/sbs_chk.sv]
`default_nettype none
module sbs_chk
  import sbs_pkg::*;
#(
  parameter int LANES = 4
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire sbs_ctrl_type ctrl_i, // strobes
  input wire logic [LANES-1:0] byte_lane_write_n_i, // lanes
  input wire logic output_enable_n_i, // enable
  input wire logic sleep_request_i, // sleep
  input wire logic data_oe_o, // drive
  input wire logic parity_io_oe_o, // drive
  input wire logic asleep_o // asleep
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // starts only count while awake
  sequence rd_go;
    !asleep_o && !ctrl_i.chip_select_n && !ctrl_i.processor_addr_strobe_n;
  endsequence
  sequence wr_go;
    !asleep_o && !ctrl_i.chip_select_n && ctrl_i.processor_addr_strobe_n
      && !ctrl_i.controller_addr_strobe_n && (!ctrl_i.global_write_n
      || (!ctrl_i.byte_write_gate_n && !(&byte_lane_write_n_i)));
  endsequence
  a_enable_gates_drive: assert property (output_enable_n_i |-> !data_oe_o)
    else $error("drive with enable high");
  a_parity_drive_pairs: assert property (parity_io_oe_o == data_oe_o)
    else $error("parity drive split");
  // read data reaches the pins one edge after the array read
  a_read_drives_late: assert property (rd_go ##1 !asleep_o
    ##1 !output_enable_n_i |-> data_oe_o) else $error("read not driven");
  a_write_no_drive: assert property (wr_go |-> ##2 !data_oe_o)
    else $error("write drove pins");
  a_deselect_no_drive: assert property (!asleep_o && ctrl_i.chip_select_n
    && !ctrl_i.controller_addr_strobe_n |-> ##2 !data_oe_o) else $error("deselect drove");
  a_sleep_enter_fast: assert property (sleep_request_i |=> asleep_o)
    else $error("sleep late");
  a_sleep_exit_late: assert property (!sleep_request_i [*2] |=> !asleep_o)
    else $error("wake late");
  a_asleep_no_drive: assert property (asleep_o |=> !data_oe_o)
    else $error("asleep drove");
  // inputs stay ignored on the first edge after the request drops
  a_sleep_holds_off: assert property ($fell(sleep_request_i) |-> asleep_o)
    else $error("woke early");
endmodule : sbs_chk
bind sbs_interface sbs_chk #(.LANES(LANES)) chk (.clk_i(clk_i), .rst_i(rst_i),
  .ctrl_i(ctrl_i), .byte_lane_write_n_i(byte_lane_write_n_i),
  .output_enable_n_i(output_enable_n_i), .sleep_request_i(sleep_request_i),
  .data_oe_o(data_oe_o), .parity_io_oe_o(parity_io_oe_o), .asleep_o(asleep_o));
`default_nettype wire

// [testbench/sbs_bus_model.sv]
`default_nettype none
module sbs_bus_model (
  input wire logic clk_i, // clock
  input wire logic [35:0] host_i, // write data
  input wire logic host_oe_i, // host drives
  input wire logic [35:0] dev_i, // read data
  input wire logic dev_oe_i, // device drives
  output logic [35:0] pin_o // pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] last = 36'h0;
  // floating pins flip so stale data never passes
  always_ff @(posedge clk_i)
    last <= pin_o;
  always_comb
    if (host_oe_i)
      pin_o = host_i;
    else if (dev_oe_i)
      pin_o = dev_i;
    else
      pin_o = ~last;
endmodule : sbs_bus_model
`default_nettype wire

// [testbench/testbench.sv]
`default_nettype none
module testbench
  import sbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] IDL = 6'h37;
  logic clk_i = 0, rst_i = 1, oe_n = 0, ord = 1, slp = 0, hdrv = 0, doe, poe, slp_o;
  logic [5:0] ctrl = IDL;
  logic [9:0] addr = 10'h0;
  logic [3:0] lanes = 4'hf;
  logic [35:0] hd = 36'h0, pin, q;
  logic [35:0] m [1024];
  int errors = 0, samples_checked = 0;
  always #10 clk_i = ~clk_i;
  sbs_interface dut (.clk_i(clk_i), .rst_i(rst_i), .ctrl_i(ctrl), .addr_i(addr),
    .byte_lane_write_n_i(lanes), .output_enable_n_i(oe_n), .burst_order_i(ord),
    .sleep_request_i(slp), .data_i(pin[31:0]), .data_o(q[31:0]), .data_oe_o(doe),
    .parity_io_i(pin[35:32]), .parity_io_o(q[35:32]), .parity_io_oe_o(poe), .asleep_o(slp_o));
  sbs_bus_model bus (.clk_i(clk_i), .host_i(hd), .host_oe_i(hdrv), .dev_i(q), .dev_oe_i(doe),
    .pin_o(pin));
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    samples_checked++;
    if (e !== g)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // controller-strobe start, one word
  task automatic wr(input logic [9:0] a, input logic [35:0] w, input logic g, t,
    input logic [3:0] l);
    @(posedge clk_i);
    ctrl <= {4'h5, g, t};
    addr <= a;
    lanes <= l;
    hd <= w;
    hdrv <= 1'b1;
    oe_n <= 1'b1;
    for (int j = 0; j < 4; j++)
      if (!g || (!t && !l[j]))
        m[a][j*8+:8] = w[j*8+:8];
    for (int j = 0; j < 4; j++)
      if (!g || (!t && !l[j]))
        m[a][32+j] = w[32+j];
    @(posedge clk_i);
    ctrl <= IDL;
    hdrv <= 1'b0;
  endtask : wr
  // processor start reads, the following edge writes at the held address
  task automatic pwr(input logic [9:0] a, input logic [35:0] w);
    @(posedge clk_i);
    ctrl <= 6'h0f;
    addr <= a;
    oe_n <= 1'b1;
    @(posedge clk_i);
    ctrl <= 6'h3d;
    hd <= w;
    hdrv <= 1'b1;
    m[a] = w;
    @(posedge clk_i);
    ctrl <= IDL;
    hdrv <= 1'b0;
  endtask : pwr
  // processor start with global write low, then steps s[3:1]
  task automatic rd(input logic [9:0] a, input logic [3:0] s, input logic n);
    logic [1:0] c;
    logic [9:0] x [4];
    c = 2'h0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      ctrl <= i == 0 ? 6'h0d : (i < 4 ? {3'h7, s[i], 2'h3} : IDL);
      addr <= a;
      oe_n <= n;
      if (i > 0 && i < 4 && !s[i])
        c++;
      if (i < 4)
        x[i] = {a[9:2], ord ? a[1:0] ^ c : a[1:0] + c};
      #1;
      // data of the access taken at one edge shows after the next edge
      if (i > 1)
        chk("drive", {34'h0, {2{!n && i < 6}}}, {34'h0, doe, poe});
      if (i > 1 && i < 6 && !n)
        chk("data", m[x[i-2]], q);
    end
  endtask : rd
  // start during sleep is dropped; wake needs two edges
  task automatic nap;
    @(posedge clk_i);
    slp <= 1'b1;
    oe_n <= 1'b0;
    @(posedge clk_i);
    ctrl <= 6'h0d;
    @(posedge clk_i);
    ctrl <= IDL;
    // a wrongly taken start would drive here
    @(posedge clk_i);
    #1;
    chk("nap drive", 36'h0, {35'h0, doe});
    @(posedge clk_i);
    slp <= 1'b0;
    #1;
    chk("asleep", 36'h1, {35'h0, slp_o});
    @(posedge clk_i);
  endtask : nap
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("idle drive", 36'h0, {34'h0, doe, poe});
    for (int k = 0; k < 8; k++)
      wr(10'(k), {k[3:0], {4{k[3:0], 4'h5}}}, 1'b0, 1'b1, 4'h0);
    wr(10'h1, 36'h9_1234_5678, 1'b1, 1'b0, 4'hd);
    wr(10'h2, 36'hf_ffff_ffff, 1'b1, 1'b1, 4'h0);
    pwr(10'h4, 36'ha_c3c3_5a5a);
    rd(10'h4, 4'he, 1'b0);
    rd(10'h2, 4'h4, 1'b0);
    rd(10'h5, 4'h0, 1'b0);
    rd(10'h6, 4'h0, 1'b1);
    nap();
    rd(10'h1, 4'h0, 1'b0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    ord <= 1'b0;
    @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("reset data", 36'h0, q);
    rd(10'h3, 4'h0, 1'b0);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
